// file: rtl/svm_irq.sv
// Sticky interrupt status with mask and one level interrupt output.
// Assumes events are one-cycle pulses; a read of the status clears it.
`timescale 1ns/1ps
`default_nettype none

module svm_irq #(
    parameter int W = svm_pkg::INT_W
) (
    input wire logic clk_i,              // Clock
    input wire logic rst_i,              // Synchronous reset
    input wire logic [W-1:0] event_i,    // Event pulses
    input wire logic rd_clear_i,         // Status read, clears all bits
    input wire logic mask_wr_i,          // Mask write strobe
    input wire logic [W-1:0] mask_dat_i, // Mask write data
    output logic [W-1:0] status_o,       // Sticky status
    output logic [W-1:0] mask_o,         // Mask, 1 enables
    output logic irq_o                   // Level interrupt
);
    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] mask;
    } svm_irq_state_t;

    svm_irq_state_t st;
    svm_irq_state_t next_st;

    if (W < 1 || W > 32) begin : g_chk
        $error("svm_irq needs W between 1 and 32");
    end

    always_comb begin
        next_st = st;
        // A new event in the clearing cycle survives
        next_st.status = (rd_clear_i ? '0 : st.status) | event_i;
        if (mask_wr_i) begin
            next_st.mask = mask_dat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign status_o = st.status;
    assign mask_o = st.mask;
    assign irq_o = |(st.status & st.mask);
endmodule : svm_irq

`default_nettype wire

// file: rtl/svm_pkg.sv
// Constants and carrier types for the supply voltage monitor control block.
// Assumes a 32-bit classic Wishbone register bus and an analog comparator outside.
//
// How it works
// - A crossing of the trip point in the chosen direction sets the interrupt flag, which raises the interrupt when unmasked.
// - Control bit 15 powers the monitor; clearing it stops all detection activity.
// - With bit 13 set the monitor halts while the device idles, otherwise it keeps running.
// - Bit 11 picks the event: 1 means supply at or above the trip point, 0 below it.
// - Bit 10 is hardware-owned and shows that the band gap is stable.
// - Bit 9 shows that the internal reference is stable, and no interrupt flag is made while it is 0.
// - Bit 8 is hardware-owned and shows that a detection event is active.
// - Level code 1111 compares the external sense pin against the band gap instead of the supply.
// - Codes 1110 down to 0101 pick rising supply trip points and go straight to the comparator ladder.
// - Bits 31 to 16, 14, 12 and 7 to 4 read as zero and ignore writes.
// - Clear, set and invert aliases sit at the register address plus 4, 8 and 12.
// - In idle the clocks keep running, and only a monitor with its idle-stop bit set halts.
// - The module-disable input freezes the block, drops register writes and returns no valid reads.

package svm_pkg;
    localparam logic [15:0] CTRL_ADDR = 16'h2310;
    localparam logic [15:0] CLR_OFS = 16'h0004;
    localparam logic [15:0] SET_OFS = 16'h0008;
    localparam logic [15:0] INV_OFS = 16'h000c;
    localparam logic [15:0] INT_STAT_ADDR = 16'h2320;
    localparam logic [15:0] INT_MASK_ADDR = 16'h2324;

    localparam int ON_BIT = 15;
    localparam int IDLE_BIT = 13;
    localparam int DIR_BIT = 11;
    localparam int BG_BIT = 10;
    localparam int REF_BIT = 9;
    localparam int EVT_BIT = 8;
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 4;

    localparam logic [31:0] WRITABLE_MASK = 32'h0000_a80f;
    localparam logic [31:0] IMPL_MASK = 32'h0000_af0f;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [LEVEL_W-1:0] LEVEL_EXTERNAL = 4'hf;

    localparam int INT_W = 1;
    localparam logic [INT_W-1:0] INT_RESET = 1'h0;

    typedef struct packed {
        logic power;
        logic external_sel;
        logic dir;
        logic [LEVEL_W-1:0] level;
    } svm_analog_t;

    typedef struct packed {
        logic above;
        logic bandgap;
        logic reference;
    } svm_sense_t;
endpackage : svm_pkg

// file: rtl/svm_sync3.sv
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous levels; a change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module svm_sync3 #(
    parameter int W = 3
) (
    input wire logic clk_i,           // Clock
    input wire logic rst_i,           // Synchronous reset
    input wire logic [W-1:0] async_i, // Asynchronous levels
    output logic [W-1:0] sync_o       // Filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } svm_sync_state_t;

    svm_sync_state_t st;
    svm_sync_state_t next_st;

    if (W < 1) begin : g_chk
        $error("svm_sync3 needs W of at least 1");
    end

    always_comb begin
        next_st = st;
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.val = (st.s2 & st.s3) | (st.val & (st.s2 | st.s3));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.val;
endmodule : svm_sync3

`default_nettype wire

// file: rtl/svm_top.sv
// Supply voltage monitor control: register slave, event logic and interrupt.
// Assumes a classic Wishbone master on clk_i and an analog comparator on sense_i.
`timescale 1ns/1ps
`default_nettype none

module svm_top #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,                    // Clock, 125 MHz
    input wire logic rst_i,                    // Synchronous reset
    input wire logic wb_cyc_i,                 // Bus cycle
    input wire logic wb_stb_i,                 // Strobe
    input wire logic wb_we_i,                  // Write enable
    input wire logic [ADDR_W-1:0] wb_adr_i,    // Byte address
    input wire logic [3:0] wb_sel_i,           // Byte lanes
    input wire logic [31:0] wb_dat_i,          // Write data
    output logic [31:0] wb_dat_o,              // Read data
    output logic wb_ack_o,                     // Acknowledge
    input wire logic idle_mode_i,              // Device in idle
    input wire logic monitor_module_disable_i, // Module disable
    input wire svm_pkg::svm_sense_t sense_i,   // Analog status, async
    output svm_pkg::svm_analog_t analog_o,     // Analog controls
    output logic irq_o                         // Interrupt, level
);
    typedef struct packed {
        logic on;
        logic idle_stop;
        logic dir;
        logic [svm_pkg::LEVEL_W-1:0] level;
        logic bg_flag;
        logic ref_flag;
        logic evt_flag;
        logic ack;
        logic [31:0] rdata;
    } svm_state_t;

    svm_state_t st;
    svm_state_t next_st;
    svm_pkg::svm_sense_t sense;
    logic [svm_pkg::INT_W-1:0] int_status;
    logic [svm_pkg::INT_W-1:0] int_mask;
    logic req;
    logic run;
    logic match;
    logic evt_rise;
    logic rd_clear;
    logic mask_wr;
    logic md;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic [31:0] cur;
    logic [31:0] upd;

    if (ADDR_W < 16 || ADDR_W > 32) begin : g_chk
        $error("svm_top needs ADDR_W between 16 and 32");
    end

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction : lane_mask

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] b);
        logic [ADDR_W-1:0] bw;
        bw = ADDR_W'(b);
        return a[ADDR_W-1:2] == bw[ADDR_W-1:2];
    endfunction : hit

    function automatic logic [31:0] ctrl_image(input svm_state_t s);
        logic [31:0] v;
        v = svm_pkg::CTRL_RESET;
        v[svm_pkg::ON_BIT] = s.on;
        v[svm_pkg::IDLE_BIT] = s.idle_stop;
        v[svm_pkg::DIR_BIT] = s.dir;
        v[svm_pkg::BG_BIT] = s.bg_flag;
        v[svm_pkg::REF_BIT] = s.ref_flag;
        v[svm_pkg::EVT_BIT] = s.evt_flag;
        v[svm_pkg::LEVEL_LSB +: svm_pkg::LEVEL_W] = s.level;
        return v & svm_pkg::IMPL_MASK;
    endfunction : ctrl_image

    svm_sync3 #(
        .W($bits(svm_pkg::svm_sense_t))
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(sense_i),
        .sync_o(sense)
    );

    assign md = monitor_module_disable_i;

    assign run = st.on && !(st.idle_stop && idle_mode_i) && !md;

    assign match = st.dir ? sense.above : !sense.above;

    always_comb begin
        next_st = st;
        req = wb_cyc_i && wb_stb_i && !st.ack;
        wmask = lane_mask(wb_sel_i) & svm_pkg::WRITABLE_MASK;
        wd = wb_dat_i & wmask;
        cur = ctrl_image(st);
        upd = cur;
        rd_clear = 1'b0;
        mask_wr = 1'b0;
        next_st.ack = req;
        if (req && wb_we_i && !md) begin
            if (hit(wb_adr_i, svm_pkg::CTRL_ADDR)) begin
                upd = (cur & ~wmask) | wd;
            end else if (hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::CLR_OFS)) begin
                upd = cur & ~wd;
            end else if (hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::SET_OFS)) begin
                upd = cur | wd;
            end else if (hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::INV_OFS)) begin
                upd = cur ^ wd;
            end
            mask_wr = hit(wb_adr_i, svm_pkg::INT_MASK_ADDR) && wb_sel_i[0];
        end
        next_st.on = upd[svm_pkg::ON_BIT];
        next_st.idle_stop = upd[svm_pkg::IDLE_BIT];
        next_st.dir = upd[svm_pkg::DIR_BIT];
        next_st.level = upd[svm_pkg::LEVEL_LSB +: svm_pkg::LEVEL_W];
        if (req && !wb_we_i) begin
            next_st.rdata = '0;
            if (md) begin
                // No valid data while the module is disabled
                next_st.rdata = '0;
            end else if (hit(wb_adr_i, svm_pkg::CTRL_ADDR) ||
                         hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::CLR_OFS) ||
                         hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::SET_OFS) ||
                         hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::INV_OFS)) begin
                next_st.rdata = cur;
            end else if (hit(wb_adr_i, svm_pkg::INT_STAT_ADDR)) begin
                next_st.rdata = 32'(int_status);
                rd_clear = 1'b1;
            end else if (hit(wb_adr_i, svm_pkg::INT_MASK_ADDR)) begin
                next_st.rdata = 32'(int_mask);
            end
        end
        // Frozen state models the stopped module clock
        if (!md) begin
            next_st.bg_flag = run && sense.bandgap;
            next_st.ref_flag = run && sense.reference;
            next_st.evt_flag = run && sense.reference && match;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt_rise = next_st.evt_flag && !st.evt_flag && !md;

    svm_irq #(
        .W(svm_pkg::INT_W)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(evt_rise),
        .rd_clear_i(rd_clear),
        .mask_wr_i(mask_wr),
        .mask_dat_i(wb_dat_i[svm_pkg::INT_W-1:0]),
        .status_o(int_status),
        .mask_o(int_mask),
        .irq_o(irq_o)
    );

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign analog_o.power = run;
    assign analog_o.external_sel = st.level == svm_pkg::LEVEL_EXTERNAL;
    assign analog_o.dir = st.dir;
    assign analog_o.level = st.level;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Flags freeze while md is high, so checks on them leave that time out
    // Bus checks look at the cycle after the edge that takes the request

    AST_IRQ_SET: assert property (
        (!st.evt_flag && !md ##1 st.evt_flag)
        |-> int_status[0] && (irq_o == int_mask[0]))
        else $error("event rise did not set interrupt status");

    AST_OFF_NO_POWER: assert property (
        !st.on |-> !analog_o.power ##1 (!st.evt_flag || st.on))
        else $error("monitor powered or active while off");

    AST_IDLE_STOP: assert property (
        (st.idle_stop && idle_mode_i) |-> !analog_o.power)
        else $error("monitor ran in idle with idle stop set");

    AST_IDLE_RUN: assert property (
        (st.on && !st.idle_stop && idle_mode_i && !md) |-> analog_o.power)
        else $error("monitor halted in idle without idle stop");

    AST_DIR_MATCH: assert property (
        (run && sense.reference && !md && (st.dir != sense.above)) |=> !st.evt_flag)
        else $error("event active against selected direction");

    AST_BG_FLAG: assert property (
        (!md && !sense.bandgap) |=> !st.bg_flag)
        else $error("band gap flag set while band gap unstable");

    AST_REF_GATE: assert property (
        $rose(int_status[0]) |-> $past(sense.reference) && $past(run))
        else $error("interrupt flag raised while reference unstable");

    AST_EXT_SEL: assert property (
        (req && wb_we_i && !md && wb_sel_i[0] && hit(wb_adr_i, svm_pkg::CTRL_ADDR))
        |=> analog_o.level == $past(wb_dat_i[svm_pkg::LEVEL_W-1:0]) &&
            analog_o.external_sel ==
            ($past(wb_dat_i[svm_pkg::LEVEL_W-1:0]) == svm_pkg::LEVEL_EXTERNAL))
        else $error("external input selection wrong");

    AST_RSVD_ZERO: assert property (
        (wb_ack_o && !$past(wb_we_i)) |-> (wb_dat_o & ~svm_pkg::IMPL_MASK) == 32'h0000_0000)
        else $error("unimplemented control bits read nonzero");

    AST_SET_ALIAS: assert property (
        (req && wb_we_i && !md && wb_sel_i == 4'hf &&
         hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::SET_OFS) && wb_dat_i[svm_pkg::ON_BIT])
        |=> st.on ##1 (st.on || $past(req)))
        else $error("set alias did not set enable");

    AST_MD_FREEZE: assert property (
        md |=> $stable(st.on) && $stable(st.level) && $stable(st.evt_flag))
        else $error("state changed while module disabled");

    AST_OFF_FLAGS: assert property (
        (!st.on && !md) [*2] |-> !st.evt_flag && !st.bg_flag && !st.ref_flag)
        else $error("flags set while monitor off");

    AST_STATUS_CLEAR: assert property (
        (req && !wb_we_i && !md && hit(wb_adr_i, svm_pkg::INT_STAT_ADDR) && !evt_rise)
        |=> !int_status[0])
        else $error("status read did not clear interrupt flag");

    AST_CLR_ALIAS: assert property (
        (req && wb_we_i && !md && wb_sel_i == 4'hf &&
         hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::CLR_OFS) && wb_dat_i[svm_pkg::ON_BIT])
        |=> !st.on)
        else $error("clear alias did not clear enable");

    AST_INV_ALIAS: assert property (
        (req && wb_we_i && !md && wb_sel_i == 4'hf &&
         hit(wb_adr_i, svm_pkg::CTRL_ADDR + svm_pkg::INV_OFS))
        |=> st.dir == ($past(st.dir) ^ $past(wb_dat_i[svm_pkg::DIR_BIT])))
        else $error("invert alias did not toggle direction");

    AST_MD_READ_ZERO: assert property (
        (req && !wb_we_i && md) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("read returned data while module disabled");

    AST_BG_PASS: assert property (
        (run && sense.bandgap) |=> st.bg_flag)
        else $error("band gap flag missed while band gap stable");

    AST_EVT_NEEDS_REF: assert property (
        (st.evt_flag && !$past(md)) |-> $past(sense.reference) && $past(run))
        else $error("event active while reference unstable");

    AST_EVT_PASS: assert property (
        (run && sense.reference && (st.dir == sense.above)) |=> st.evt_flag)
        else $error("event not shown although condition holds");

    AST_IDLE_FLAGS: assert property (
        (st.idle_stop && idle_mode_i && !md) |=> !st.evt_flag && !st.ref_flag)
        else $error("flags kept while idle stopped");

    AST_LEVEL_OUT: assert property (
        (wb_ack_o && !$past(wb_we_i) && !$past(md) && hit($past(wb_adr_i), svm_pkg::CTRL_ADDR))
        |-> wb_dat_o[svm_pkg::LEVEL_LSB +: svm_pkg::LEVEL_W] == analog_o.level)
        else $error("ladder code differs from control level");
endmodule : svm_top

`default_nettype wire

// file: tb/svm_analog_model.sv
// Behavioural comparator and band gap reference beside the monitor block.
// Assumes the block drives analog_i; supply and sense pin levels come in mV.
`timescale 1ns/1ps
`default_nettype none

module svm_analog_model #(
    parameter logic [15:0] LADDER [16] = '{default: 16'hffff},
    parameter int REF_DLY = 30
) (
    input wire logic clk_i,                      // Clock
    input wire logic rst_i,                      // Synchronous reset
    input wire svm_pkg::svm_analog_t analog_i,   // Controls from block
    input wire logic [15:0] supply_mv_i,         // Supply, mV
    input wire logic [15:0] ext_mv_i,            // Sense pin, mV
    output svm_pkg::svm_sense_t sense_o          // Comparator and flags
);
    logic [7:0] cnt;
    logic cmp;
    assign cmp = (analog_i.external_sel ? ext_mv_i : supply_mv_i) >= LADDER[analog_i.level];
    // Unpowered comparator output wanders, so it toggles rather than holding
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            sense_o <= '0;
        end else begin
            cnt <= !analog_i.power ? 8'h00 : (cnt == 8'hff) ? cnt : cnt + 8'h01;
            sense_o.above <= analog_i.power ? cmp : ~sense_o.above;
            sense_o.bandgap <= analog_i.power && (cnt >= 8'h0a);
            sense_o.reference <= analog_i.power && (cnt >= REF_DLY[7:0]);
        end
    end
endmodule : svm_analog_model

`default_nettype wire

// file: tb/tb_top.sv
// Register-level bench for the supply voltage monitor control block.
// Assumes the analog model stands in for the comparator; one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [15:0] C = svm_pkg::CTRL_ADDR;
    localparam logic [15:0] S = svm_pkg::INT_STAT_ADDR;
    localparam logic [15:0] M = svm_pkg::INT_MASK_ADDR;
    localparam logic [15:0] TRIP [16] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
        16'h0d70, 16'h0c3a, 16'h0b68, 16'h0b04, 16'h0a46, 16'h09d8, 16'h0960, 16'h08fc,
        16'h08a2, 16'h083e, 16'h04b0};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [3:0] lanes = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic idle = 1'b0;
    logic dis = 1'b0;
    logic [15:0] supply = 16'h0bb8;
    logic [15:0] ext = 16'h0000;
    svm_pkg::svm_sense_t sense;
    svm_pkg::svm_analog_t analog;
    logic irq;
    logic [31:0] rd;
    int mismatches = 0;
    int total_checks = 0;

    svm_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .idle_mode_i(idle), .monitor_module_disable_i(dis), .sense_i(sense),
        .analog_o(analog), .irq_o(irq));
    svm_analog_model #(.LADDER(TRIP), .REF_DLY(30)) partner (.clk_i(clk_i), .rst_i(rst_i),
        .analog_i(analog), .supply_mv_i(supply), .ext_mv_i(ext), .sense_o(sense));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Classic cycle: hold until the edge that samples ack high, take data there, then release
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        // Ack stands one cycle after the taking edge, so the second edge sees it
        check("ack latency", 32'(n), 32'h2);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string name, input logic [15:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    // only documented level codes are ever written
    task automatic setin(input logic [15:0] s, input logic [15:0] e, input logic i,
        input logic d);
        @(posedge clk_i);
        supply <= s;
        ext <= e;
        idle <= i;
        dis <= d;
    endtask : setin

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl reset", C, 32'h0);
        settle(0);
        check("irq reset", irq, 32'h0);
        wr(C, 32'hffff_57f5);
        rdchk("ctrl unimpl", C, 32'h0000_0005);
        wr(16'h2330, 32'hffff_ffff);
        rdchk("unmapped", 16'h2330, 32'h0);
        $display("test 1 done");
        wr(M, 32'h1);
        setin(16'h07d0, 16'h0000, 1'b0, 1'b0);
        wr(C, 32'h0000_800e);
        settle(14);
        check("irq early", irq, 32'h0);
        rdchk("ctrl bg", C, 32'h0000_840e);
        settle(30);
        check("irq set", irq, 32'h1);
        rdchk("ctrl evt", C, 32'h0000_870e);
        rdchk("status", S, 32'h1);
        settle(0);
        check("irq clr", irq, 32'h0);
        setin(16'h0bb8, 16'h0000, 1'b0, 1'b0);
        settle(8);
        rdchk("ctrl above", C, 32'h0000_860e);
        $display("test 2 done");
        wr(M, 32'h0);
        wr(C + svm_pkg::INV_OFS, 32'h0000_0800);
        settle(8);
        check("irq masked", irq, 32'h0);
        rdchk("ctrl inv", C, 32'h0000_8f0e);
        wr(M, 32'h1);
        settle(0);
        check("irq unmask", irq, 32'h1);
        rdchk("status", S, 32'h1);
        $display("test 3 done");
        for (int i = 5; i < 15; i++) begin
            wr(C, {28'h0000_880, i[3:0]});
            setin(TRIP[i], 16'h0000, 1'b0, 1'b0);
            settle(8);
            check("level", analog.level, i[3:0]);
            rdchk("at trip", C, {28'h0000_8f0, i[3:0]});
            setin(TRIP[i] - 16'h0001, 16'h0000, 1'b0, 1'b0);
            settle(8);
            rdchk("below", C, {28'h0000_8e0, i[3:0]});
        end
        rdchk("status", S, 32'h1);
        $display("test 4 done");
        wr(C + svm_pkg::SET_OFS, 32'h0000_000f);
        setin(16'h0bb8, 16'h03e8, 1'b0, 1'b0);
        settle(8);
        check("analog ext", analog, 32'h7f);
        rdchk("ext low", C, 32'h0000_8e0f);
        setin(16'h0bb8, 16'h0514, 1'b0, 1'b0);
        settle(8);
        rdchk("ext high", C, 32'h0000_8f0f);
        $display("test 5 done");
        setin(16'h0bb8, 16'h0514, 1'b1, 1'b0);
        settle(1);
        check("idle run", analog.power, 32'h1);
        wr(C + svm_pkg::SET_OFS, 32'h0000_2000);
        settle(0);
        check("idle stop", analog.power, 32'h0);
        rdchk("ctrl idle", C, 32'h0000_a80f);
        setin(16'h0bb8, 16'h0514, 1'b0, 1'b0);
        settle(1);
        check("idle exit", analog.power, 32'h1);
        $display("test 6 done");
        setin(16'h0bb8, 16'h0514, 1'b0, 1'b1);
        wr(C, 32'h0000_0005);
        rdchk("ctrl dis", C, 32'h0);
        setin(16'h0bb8, 16'h0514, 1'b0, 1'b0);
        wb(1'b0, C, 32'h0);
        check("ctrl kept", rd & svm_pkg::WRITABLE_MASK, 32'h0000_a80f);
        wr(C + svm_pkg::CLR_OFS, 32'h0000_8000);
        settle(0);
        check("power off", analog.power, 32'h0);
        rdchk("ctrl off", C, 32'h0000_280f);
        wr(C + svm_pkg::SET_OFS, 32'h0000_8000);
        rdchk("ctrl set on", C, 32'h0000_a80f);
        // Lane 0 only: the enable bit in lane 1 must survive a zero there
        lanes = 4'h1;
        wr(C, 32'h0000_0005);
        lanes = 4'hf;
        rdchk("ctrl lane0", C, 32'h0000_a805);
        $display("test 7 done");
        results();
    end
endmodule : tb_top

`default_nettype wire
